// ---- src/char_clock_divider.sv ----
// character clock divider: one-cycle enable every character time
// assumes a synchronised active-low reset on mclk
module char_clock_divider (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_sync_n,
  // character enable
  char_tick_if.source ticks
);
  logic [2:0] div_count;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_count <= 3'h0;
    end else if (div_count == crt_pkg::CHAR_DIV_LAST) begin
      div_count <= 3'h0;
    end else begin
      div_count <= div_count + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ticks.tick <= 1'b0;
    end else begin
      ticks.tick <= (div_count == crt_pkg::CHAR_DIV_LAST);
    end
  end
endmodule

// ---- src/char_tick_if.sv ----
// interface: character time enable passed from the divider to the counters
// assumes both ends run on mclk
interface char_tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface

// ---- src/crt_pkg.sv ----
// package: register map, reset values and timing constants of the raster generator
// assumes a 40 MHz mclk and an apb master with 32-bit data
package crt_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] ADDR_H_TOTAL = 12'h000;
  localparam logic [11:0] ADDR_H_DISP = 12'h004;
  localparam logic [11:0] ADDR_H_SYNC_POS = 12'h008;
  localparam logic [11:0] ADDR_H_SYNC_WIDTH = 12'h00c;
  localparam logic [11:0] ADDR_V_TOTAL = 12'h010;
  localparam logic [11:0] ADDR_V_ADJUST = 12'h014;
  localparam logic [11:0] ADDR_V_DISP = 12'h018;
  localparam logic [11:0] ADDR_V_SYNC_POS = 12'h01c;
  localparam logic [11:0] ADDR_SCAN_MODE = 12'h020;
  localparam logic [11:0] ADDR_MAX_SCAN = 12'h024;
  localparam logic [11:0] ADDR_STATUS = 12'h028;
  // status word field positions
  localparam int ST_HCOUNT_LSB = 0;
  localparam int ST_ROW_LSB = 8;
  localparam int ST_SCAN_LSB = 16;
  localparam int ST_HSYNC_BIT = 24;
  localparam int ST_VSYNC_BIT = 25;
  localparam int ST_DISP_BIT = 26;
  localparam int ST_ADJUST_BIT = 27;
  // values after reset: an 80 x 24 screen at about 197 hz
  localparam logic [7:0] RST_H_TOTAL = 8'h5c;
  localparam logic [7:0] RST_H_DISP = 8'h50;
  localparam logic [7:0] RST_H_SYNC_POS = 8'h51;
  localparam logic [3:0] RST_H_SYNC_WIDTH = 4'h8;
  localparam logic [6:0] RST_V_TOTAL = 7'h19;
  localparam logic [4:0] RST_V_ADJUST = 5'h0d;
  localparam logic [6:0] RST_V_DISP = 7'h18;
  localparam logic [6:0] RST_V_SYNC_POS = 7'h1a;
  localparam logic [1:0] RST_SCAN_MODE = 2'h0;
  localparam logic [4:0] RST_MAX_SCAN = 5'h09;
  // mclk cycles per character time
  localparam int CHAR_DIV_CYCLES = 8;
  localparam logic [2:0] CHAR_DIV_LAST = 3'h7;
  // vertical sync length in scan lines, fixed
  localparam logic [4:0] VSYNC_LINES = 5'h10;
  typedef enum logic [1:0] {
    V_ROWS = 2'b01,
    V_ADJUST = 2'b10
  } vphase_t;
endpackage

// ---- src/crt_raster_timing_generator.sv ----
// raster timing generator: apb register file, character and row counters, syncs
// assumes an apb master on mclk and a monitor taking sync and display enable
//
// Local design decisions: register access over APB and the register addresses.
module crt_raster_timing_generator (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // monitor side
  output logic horizontal_sync_out,
  output logic vertical_sync_out,
  output logic display_enable
);
  logic rst_meta_n;
  logic rst_sync_n;
  logic [7:0] horizontal_total;
  logic [7:0] horizontal_displayed;
  logic [7:0] horizontal_sync_position;
  logic [3:0] horizontal_sync_width;
  logic [6:0] vertical_total;
  logic [4:0] vertical_total_adjust;
  logic [6:0] vertical_displayed;
  logic [6:0] vertical_sync_position;
  logic [1:0] scan_mode_select;
  logic [4:0] max_scan_line;
  logic [7:0] hcount;
  logic [6:0] row;
  logic [4:0] scan;
  logic [4:0] adj_count;
  crt_pkg::vphase_t vphase;
  logic [3:0] hsync_left;
  logic [4:0] vsync_left;
  logic wr_en;
  logic tick;
  logic line_end;
  logic line_start;
  logic hs_start;
  logic vs_start;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [31:0] status_word;
  logic [4:0] hs_high_ticks;
  logic [3:0] hs_width_seen;
  logic [4:0] vs_high_lines;

  // true once a counter has reached its limit; >= keeps a counter
  // from running away when software shrinks a limit mid-frame
  function automatic logic reached(input logic [7:0] cnt, input logic [7:0] lim);
    reached = (cnt >= lim);
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  char_tick_if tick_bus ();

  char_clock_divider u_divider (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .ticks(tick_bus.source)
  );

  assign tick = tick_bus.tick;
  assign line_end = tick && reached(hcount, horizontal_total);
  assign line_start = tick && (hcount == 8'h00);
  assign hs_start = tick && (hcount == horizontal_sync_position) &&
    (horizontal_sync_width != 4'h0);
  assign vs_start = line_start && (scan == 5'h00) && (vphase == crt_pkg::V_ROWS) &&
    (row == vertical_sync_position);
  assign wr_en = psel && penable && pready && pwrite;

  // register writes
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      horizontal_total <= crt_pkg::RST_H_TOTAL;
      horizontal_displayed <= crt_pkg::RST_H_DISP;
      horizontal_sync_position <= crt_pkg::RST_H_SYNC_POS;
      horizontal_sync_width <= crt_pkg::RST_H_SYNC_WIDTH;
      vertical_total <= crt_pkg::RST_V_TOTAL;
      vertical_total_adjust <= crt_pkg::RST_V_ADJUST;
      vertical_displayed <= crt_pkg::RST_V_DISP;
      vertical_sync_position <= crt_pkg::RST_V_SYNC_POS;
      scan_mode_select <= crt_pkg::RST_SCAN_MODE;
      max_scan_line <= crt_pkg::RST_MAX_SCAN;
    end else if (wr_en) begin
      if (paddr == crt_pkg::ADDR_H_TOTAL) begin
        horizontal_total <= pwdata[7:0];
      end else if (paddr == crt_pkg::ADDR_H_DISP) begin
        horizontal_displayed <= pwdata[7:0];
      end else if (paddr == crt_pkg::ADDR_H_SYNC_POS) begin
        horizontal_sync_position <= pwdata[7:0];
      end else if (paddr == crt_pkg::ADDR_H_SYNC_WIDTH) begin
        horizontal_sync_width <= pwdata[3:0];
      end else if (paddr == crt_pkg::ADDR_V_TOTAL) begin
        vertical_total <= pwdata[6:0];
      end else if (paddr == crt_pkg::ADDR_V_ADJUST) begin
        vertical_total_adjust <= pwdata[4:0];
      end else if (paddr == crt_pkg::ADDR_V_DISP) begin
        vertical_displayed <= pwdata[6:0];
      end else if (paddr == crt_pkg::ADDR_V_SYNC_POS) begin
        vertical_sync_position <= pwdata[6:0];
      end else if (paddr == crt_pkg::ADDR_SCAN_MODE) begin
        scan_mode_select <= pwdata[1:0];
      end else if (paddr == crt_pkg::ADDR_MAX_SCAN) begin
        max_scan_line <= pwdata[4:0];
      end
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[crt_pkg::ST_HCOUNT_LSB +: 8] = hcount;
    status_word[crt_pkg::ST_ROW_LSB +: 7] = row;
    status_word[crt_pkg::ST_SCAN_LSB +: 5] = scan;
    status_word[crt_pkg::ST_HSYNC_BIT] = horizontal_sync_out;
    status_word[crt_pkg::ST_VSYNC_BIT] = vertical_sync_out;
    status_word[crt_pkg::ST_DISP_BIT] = display_enable;
    status_word[crt_pkg::ST_ADJUST_BIT] = (vphase == crt_pkg::V_ADJUST);
  end

  // timing registers are write-only and read as zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (paddr == crt_pkg::ADDR_STATUS) begin
      next_prdata = pwrite ? 32'h0000_0000 : status_word;
      next_slverr = pwrite;
    end else if (paddr > crt_pkg::ADDR_MAX_SCAN || paddr[1:0] != 2'h0) begin
      next_slverr = 1'b1;
    end
  end

  // no wait state: the answer is prepared in the setup cycle
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_slverr;
      if (psel && !penable) begin
        prdata <= next_prdata;
      end
    end
  end

  // character counter
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hcount <= 8'h00;
    end else if (line_end) begin
      hcount <= 8'h00;
    end else if (tick) begin
      hcount <= hcount + 8'h01;
    end
  end

  // vertical sequencer; only the non-interlaced raster is built, since
  // software leaves the scan mode at zero
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vphase <= crt_pkg::V_ROWS;
      row <= 7'h00;
      scan <= 5'h00;
      adj_count <= 5'h00;
    end else if (line_end) begin
      case (vphase)
        crt_pkg::V_ROWS: begin
          if (reached({3'h0, scan}, {3'h0, max_scan_line})) begin
            scan <= 5'h00;
            if (reached({1'b0, row}, {1'b0, vertical_total})) begin
              adj_count <= 5'h00;
              if (vertical_total_adjust != 5'h00) begin
                vphase <= crt_pkg::V_ADJUST;
              end else begin
                row <= 7'h00;
              end
            end else begin
              row <= row + 7'h01;
            end
          end else begin
            scan <= scan + 5'h01;
          end
        end
        crt_pkg::V_ADJUST: begin
          if (reached({3'h0, adj_count + 5'h01}, {3'h0, vertical_total_adjust})) begin
            vphase <= crt_pkg::V_ROWS;
            row <= 7'h00;
            adj_count <= 5'h00;
          end else begin
            adj_count <= adj_count + 5'h01;
          end
        end
        default: begin
          vphase <= crt_pkg::V_ROWS;
          row <= 7'h00;
        end
      endcase
    end
  end

  // horizontal sync pulse
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hsync_left <= 4'h0;
      horizontal_sync_out <= 1'b0;
    end else if (tick) begin
      if (hs_start) begin
        hsync_left <= horizontal_sync_width - 4'h1;
        horizontal_sync_out <= 1'b1;
      end else if (hsync_left != 4'h0) begin
        hsync_left <= hsync_left - 4'h1;
        horizontal_sync_out <= 1'b1;
      end else begin
        horizontal_sync_out <= 1'b0;
      end
    end
  end

  // vertical sync pulse, counted in scan lines at each line start
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vsync_left <= 5'h00;
      vertical_sync_out <= 1'b0;
    end else if (line_start) begin
      if (vs_start) begin
        vsync_left <= crt_pkg::VSYNC_LINES - 5'h01;
        vertical_sync_out <= 1'b1;
      end else if (vsync_left != 5'h00) begin
        vsync_left <= vsync_left - 5'h01;
        vertical_sync_out <= 1'b1;
      end else begin
        vertical_sync_out <= 1'b0;
      end
    end
  end

  // display enable lags the counters by one character, like the syncs
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      display_enable <= 1'b0;
    end else if (tick) begin
      display_enable <= (hcount < horizontal_displayed) &&
        (row < vertical_displayed) && (vphase == crt_pkg::V_ROWS);
    end
  end

  // pulse-length helpers restart at each pulse start, so a restart or a
  // width written mid-pulse by software cannot upset the checks
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hs_high_ticks <= 5'h00;
      hs_width_seen <= 4'h0;
    end else if (hs_start) begin
      hs_high_ticks <= 5'h00;
      hs_width_seen <= horizontal_sync_width;
    end else if (tick) begin
      hs_high_ticks <= horizontal_sync_out ? hs_high_ticks + 5'h01 : 5'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vs_high_lines <= 5'h00;
    end else if (vs_start) begin
      vs_high_lines <= 5'h00;
    end else if (line_start) begin
      vs_high_lines <= vertical_sync_out ? vs_high_lines + 5'h01 : 5'h00;
    end
  end

  AST_TICK_SPACING: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    tick |=> !tick [*7] ##1 tick)
    else $error("character enable spacing wrong");

  AST_HCOUNT_WRAP: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    tick && hcount >= horizontal_total |=> hcount == 8'h00)
    else $error("character counter did not wrap at total");

  AST_HCOUNT_STEP: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    tick && hcount < horizontal_total |=> hcount == $past(hcount) + 8'h01)
    else $error("character counter did not advance");

  AST_HSYNC_START: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    hs_start |=> horizontal_sync_out)
    else $error("horizontal sync missed its position");

  AST_HSYNC_WIDTH: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    $fell(horizontal_sync_out) |-> hs_high_ticks == {1'b0, hs_width_seen})
    else $error("horizontal sync width wrong");

  AST_DISPLAY: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    tick |=> display_enable == ($past(hcount) < $past(horizontal_displayed) &&
      $past(row) < $past(vertical_displayed) && $past(vphase) == crt_pkg::V_ROWS))
    else $error("display enable outside displayed area");

  AST_SCAN_WRAP: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    line_end && vphase == crt_pkg::V_ROWS && scan >= max_scan_line |=> scan == 5'h00)
    else $error("scan line did not wrap at maximum");

  AST_VTOTAL_ADJUST: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    line_end && vphase == crt_pkg::V_ROWS && scan >= max_scan_line &&
      row >= vertical_total && vertical_total_adjust != 5'h00
    |=> vphase == crt_pkg::V_ADJUST && row == $past(row))
    else $error("adjust lines did not follow last row");

  AST_FRAME_END: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    line_end && vphase == crt_pkg::V_ADJUST && adj_count + 5'h01 >= vertical_total_adjust
    |=> vphase == crt_pkg::V_ROWS && row == 7'h00 && scan == 5'h00)
    else $error("frame did not restart after adjust");

  AST_VSYNC_START: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    vs_start |=> vertical_sync_out)
    else $error("vertical sync missed its row");

  AST_VSYNC_WIDTH: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    $fell(vertical_sync_out) |-> vs_high_lines == crt_pkg::VSYNC_LINES)
    else $error("vertical sync not sixteen lines");
endmodule

// ---- verif/crt_monitor_model.sv ----
// monitor model: measures sync and display enable spans in mclk cycles
// assumes the generator changes its outputs only at rising mclk edges
module crt_monitor_model (
  // clock
  input wire logic mclk,
  // sync and visible area from the generator
  input wire logic horizontal_sync_out,
  input wire logic vertical_sync_out,
  input wire logic display_enable,
  // measured spans
  output int line_len,
  output int hs_width,
  output int hs_offset,
  output int de_width,
  output int frame_len,
  output int vs_width,
  output int vs_offset,
  output int de_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  int t = 0;
  int hr = 0;
  int vr = 0;
  int dr = 0;
  int top = 0;
  int acc = 0;
  logic hp = 1'b0;
  logic vp = 1'b0;
  logic dp = 1'b0;
  logic seen = 1'b0;
  // a receiver only: it drives nothing back, so no far-side rule applies
  always @(posedge mclk) begin
    t++;
    if (display_enable && !dp) begin
      // a gap longer than one line plus 8 cycles marks the top of a frame
      if (t - dr > line_len + 8)
        top = t;
      dr = t;
      seen = 1'b1;
      acc++;
    end
    if (!display_enable && dp)
      de_width = t - dr;
    if (horizontal_sync_out && !hp) begin
      line_len = t - hr;
      hr = t;
      if (seen)
        hs_offset = t - dr;
      seen = 1'b0;
    end
    if (!horizontal_sync_out && hp)
      hs_width = t - hr;
    if (vertical_sync_out && !vp) begin
      frame_len = t - vr;
      vr = t;
      vs_offset = t - top;
      de_lines = acc;
      acc = 0;
    end
    if (!vertical_sync_out && vp)
      vs_width = t - vr;
    hp = horizontal_sync_out;
    vp = vertical_sync_out;
    dp = display_enable;
  end
endmodule

// ---- verif/crt_raster_timing_generator_bench.sv ----
// bench: programs the generator over apb and checks measured raster timing
// assumes the monitor model measures spans in mclk cycles
module crt_raster_timing_generator_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int C = crt_pkg::CHAR_DIV_CYCLES;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic horizontal_sync_out;
  logic vertical_sync_out;
  logic display_enable;
  int line_len, hs_width, hs_offset, de_width, frame_len, vs_width, vs_offset, de_lines;
  int err_count = 0;
  int checked = 0;
  int r;
  logic [7:0] cfg [10];
  logic [31:0] rd;
  logic er;

  crt_raster_timing_generator u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .horizontal_sync_out(horizontal_sync_out),
    .vertical_sync_out(vertical_sync_out), .display_enable(display_enable));

  crt_monitor_model u_mon (.mclk(mclk), .horizontal_sync_out(horizontal_sync_out),
    .vertical_sync_out(vertical_sync_out), .display_enable(display_enable),
    .line_len(line_len), .hs_width(hs_width), .hs_offset(hs_offset), .de_width(de_width),
    .frame_len(frame_len), .vs_width(vs_width), .vs_offset(vs_offset), .de_lines(de_lines));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task end_of_test;
    $display("counts: %0d checks, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; waits for pready rather than assuming a latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
      chk(32'h0, 32'h1, "no ready");
  endtask

  task wait_rise(input logic vert, input int n);
    int k;
    k = 0;
    repeat (n) begin
      while ((vert ? vertical_sync_out : horizontal_sync_out) !== 1'b0 && k < 60000) begin
        @(posedge mclk);
        k++;
      end
      while ((vert ? vertical_sync_out : horizontal_sync_out) !== 1'b1 && k < 60000) begin
        @(posedge mclk);
        k++;
      end
    end
    if (k >= 60000)
      chk(32'h0, 32'h1, "sync missing");
    @(negedge mclk);
  endtask

  function automatic int frame_lines();
    return (cfg[4] + 1) * (cfg[9] + 1) + cfg[5];
  endfunction

  // two whole frames after the writes so a mid-frame change has settled
  task run_cfg(input string name);
    int ln;
    for (int i = 0; i < 10; i++)
      apb(1'b1, 12'(i * 4), {24'h0, cfg[i]});
    wait_rise(1'b1, 3);
    ln = (cfg[0] + 1) * C;
    chk(line_len, ln, "line length");
    chk(hs_width, cfg[3] * C, "hsync width");
    chk(hs_offset, cfg[2] * C, "hsync start");
    chk(de_width, cfg[1] * C, "visible chars");
    chk(frame_len, frame_lines() * ln, "frame length");
    chk(vs_width, 16 * ln, "vsync width");
    chk(vs_offset, cfg[7] * (cfg[9] + 1) * ln, "vsync start");
    chk(de_lines, cfg[6] * (cfg[9] + 1), "visible lines");
    $display("test %s done", name);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test;
  end

  initial begin
    r = $urandom(2);
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wait_rise(1'b0, 3);
    chk(line_len, 93 * C, "reset line");
    chk(hs_width, 8 * C, "reset hsync width");
    chk(hs_offset, 81 * C, "reset hsync start");
    chk(de_width, 80 * C, "reset visible chars");
    $display("test reset_timing done");
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0, "write-only read");
      chk({31'h0, er}, 32'h0, "write-only error");
    end
    apb(1'b0, 12'h02c, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b0, 12'h002, 32'h0);
    chk({31'h0, er}, 32'h1, "unaligned error");
    apb(1'b1, 12'h028, 32'h0);
    chk({31'h0, er}, 32'h1, "status write error");
    apb(1'b0, 12'h028, 32'h0);
    chk({31'h0, rd[7:0] <= 8'h5c}, 32'h1, "status char count");
    $display("test register_map done");
    cfg = '{8'h1f, 8'h08, 8'h0a, 8'h0f, 8'h07, 8'h05, 8'h03, 8'h04, 8'h00, 8'h02};
    run_cfg("wide_sync");
    repeat (3) begin
      cfg[1] = 8'(4 + $urandom % 4);
      cfg[2] = cfg[1] + 8'(1 + $urandom % 2);
      cfg[3] = 8'(1 + $urandom % 3);
      cfg[0] = cfg[2] + cfg[3] + 8'(1 + $urandom % 4);
      cfg[9] = 8'($urandom % 2);
      cfg[4] = 8'((cfg[9] != 0 ? 8 : 16) + $urandom % 3);
      cfg[6] = 8'(2 + $urandom % 4);
      cfg[7] = cfg[6] + 8'(1 + $urandom % 2);
      cfg[5] = 8'($urandom % 4);
      cfg[8] = 8'h00;
      run_cfg("random_geometry");
    end
    end_of_test;
  end
endmodule
